//--- verilog/safety_pkg.sv
// constants and types shared by the safety enable and shutdown logic
package safety_pkg;
  // clock and timebase
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int TICK_PERIOD_MS = 10;
  localparam int TICK_CYCLES    = (1000000000 / CLK_PERIOD_PS) * TICK_PERIOD_MS;
  localparam int TICKS_PER_SEC  = 1000 / TICK_PERIOD_MS;
  localparam int SEC_CNT_W      = 7;
  // input circuit timing, in ms and in 10 ms ticks
  localparam int STABLE_TIME_MS = 100;
  localparam int DISC_TIME_MS   = 10000;
  localparam int STABLE_TICKS   = STABLE_TIME_MS / TICK_PERIOD_MS;
  localparam int DISC_TICKS     = DISC_TIME_MS / TICK_PERIOD_MS;
  localparam int STABLE_CNT_W   = 4;
  localparam int DISC_CNT_W     = 10;
  // structure
  localparam int NUM_CIRCUITS   = 8;
  localparam int NUM_PATHS      = 5;
  localparam int NUM_TIMERS     = 8;
  localparam int SIGNAL_TIMER   = 5;
  localparam int LONG_TIMER0    = 6;
  localparam int NUM_LIMITS     = 4;
  localparam int LIM_RELEASE    = 0;
  localparam int LIM_ESTOP      = 3;
  localparam int ADC_W          = 12;
  localparam int DELAY_W        = 16;
  typedef logic [ADC_W-1:0]   adc_type;
  typedef logic [DELAY_W-1:0] delay_type;
  // reset values and ranges
  localparam adc_type   ADC_MAX       = 12'hfff;
  localparam delay_type DELAY_DEFAULT = 16'h0000;
  localparam delay_type SHORT_MAX     = 16'hea5f; // 599.99 s in 10 ms
  localparam delay_type LONG_MAX      = 16'hea5f; // 59999 s in 1 s
endpackage

//--- verilog/timer_if.sv
// carrier between the control logic and one delay timer
`timescale 1ns/10ps
interface timer_if;
  import safety_pkg::*;
  logic      tick;
  logic      demand;
  logic      force_off;
  delay_type delay;
  logic      out;
  logic      running;
  modport ctrl (output tick, demand, force_off, delay,
                input  out, running);
  modport tmr  (input  tick, demand, force_off, delay,
                output out, running);
endinterface

//--- verilog/delay_timer.sv
// one off-delay or on-delay timer counting timebase ticks
`timescale 1ns/10ps
module delay_timer #(
  parameter bit ON_DELAY = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  timer_if.tmr     tif
);
  import safety_pkg::*;

  delay_type count_reg;
  logic      out_reg;
  logic      waiting;
  logic      done;

  // off-delay waits while demand is low, on-delay while it is high
  assign waiting = ON_DELAY ? tif.demand : !tif.demand;
  assign done    = waiting && (count_reg >= tif.delay);

  ////////////////////////////////////////////////////////////////////////
  // tick counter, restarted whenever the wait is broken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= DELAY_DEFAULT;
    end else if (!waiting || tif.force_off) begin
      count_reg <= DELAY_DEFAULT;
    end else if (tif.tick && count_reg < tif.delay) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // output; forced off bypasses any delay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
    end else if (tif.force_off) begin
      out_reg <= 1'b0;
    end else if (ON_DELAY) begin
      out_reg <= done;
    end else begin
      out_reg <= tif.demand || (out_reg && !done);
    end
  end

  assign tif.out     = out_reg;
  assign tif.running = ON_DELAY ? (tif.demand && !out_reg)
                                : (!tif.demand && out_reg);
endmodule

//--- verilog/safety_enable_shutdown_logic.sv
// safety enable, restart handling, shutdown paths and interlock control
// Notes on behaviour
// - enable only with all active circuits closed and analogues not above limit four
// - with emergency stop in use, start needed once after power-on
// - start actuations ignored while any after-travel delay runs
// - supply drop or system failure cuts all paths, no delay
// - all sensors auto-start: area re-enables without start
// - sensors and emergency stops reset in any order
// - limit one releases interlock, two and three also bound the release, four stops
// - unlock allowed only below limit one and within the others
// - analogue above limit four acts as emergency stop
// - dual mode detects broken wire, warning only
// - five shutdown paths, each with its own delay
// - zero delay switches the path off at once
// - paths from off-delay timers, signalling output from on-delay
// - short timers up to 599.99 s in 10 ms steps
// - long timers up to 59999 s in 1 s steps
// - with interlock selected the pair drives the solenoid
// - locked when magnet contact open, or both electronic inputs low
// - leaving configuration without saving keeps the old settings
// - error view restart on selector press once cause is gone
// - standard input on when high, monitored input on echoing pulse
// - channels differing past monitoring time raise discrepancy warning
// - release only after both contacts stable for the stable time
`timescale 1ns/10ps
module safety_enable_shutdown_logic #(
  parameter int TICK_CYCLES_P = safety_pkg::TICK_CYCLES
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic [7:0]                   circuit_en,
  input  wire logic [7:0]                   channel_a,
  input  wire logic [7:0]                   channel_b,
  input  wire logic [7:0]                   cross_monitored,
  input  wire logic [7:0]                   auto_start,
  input  wire logic [7:0]                   estop_circuit,
  output      logic                         test_pulse,
  input  wire logic                         restart_input,
  input  wire safety_pkg::adc_type          analogue_channel_zero,
  input  wire safety_pkg::adc_type          analogue_channel_one,
  input  wire logic                         dual_sensor,
  input  wire safety_pkg::adc_type          dual_tolerance,
  input  wire logic                         power_fail,
  input  wire logic                         system_fault,
  input  wire logic                         error_view,
  input  wire logic                         selector_press,
  input  wire logic                         cfg_save,
  input  wire safety_pkg::adc_type [3:0]    cfg_limit_zero,
  input  wire safety_pkg::adc_type [3:0]    cfg_limit_one,
  input  wire safety_pkg::delay_type [7:0]  cfg_timer_delay,
  input  wire logic                         interlock_sel,
  input  wire logic                         interlock_electronic,
  input  wire logic                         power_to_unlock,
  input  wire logic                         lock_input_even,
  input  wire logic                         lock_input_odd,
  input  wire logic                         unlock_request,
  input  wire logic [1:0]                   long_timer_start,
  output      logic                         safety_enable,
  output      logic                         complementary_safe_output,
  output      logic                         complementary_safe_output_n,
  output      logic                         semiconductor_output_a,
  output      logic                         semiconductor_output_b,
  output      logic                         relay_output_a,
  output      logic                         relay_output_b,
  output      logic                         signalling_output_two,
  output      logic [1:0]                   long_timer_done,
  output      logic                         interlock_locked,
  output      logic                         unlock_permit,
  output      logic                         wire_break_warning,
  output      logic                         discrepancy_warning,
  output      logic                         error_active
);
  import safety_pkg::*;

  logic [20:0]           tick_cnt_reg;
  logic [SEC_CNT_W-1:0]  sec_cnt_reg;
  logic                  tick_10ms;
  logic                  tick_1s;
  logic                  test_pulse_reg;
  logic [7:0]            closed;
  logic [7:0]            disc_warn;
  adc_type [3:0]         lim0_reg;
  adc_type [3:0]         lim1_reg;
  delay_type [7:0]       delay_reg;
  logic                  start_prev_reg;
  logic                  start_seen_reg;
  logic                  run_reg;
  logic                  error_reg;
  logic                  comp_reg;
  logic                  permit_reg;
  logic                  wire_break_reg;
  logic                  circuit_ok;
  logic                  estop_used;
  logic                  auto_all;
  logic                  start_pulse;
  logic                  start_take;
  logic                  any_stop1;
  logic                  analog_trip;
  logic                  analog_release;
  logic                  forced;
  logic                  run_cond;
  logic                  solenoid_on;
  adc_type               ai_diff;
  timer_if               tif [NUM_TIMERS] ();

  ////////////////////////////////////////////////////////////////////////
  // 10 ms and 1 s timebase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 21'h000000;
    end else if (tick_10ms) begin
      tick_cnt_reg <= 21'h000000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 21'h000001;
    end
  end
  assign tick_10ms = (tick_cnt_reg == 21'(TICK_CYCLES_P - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt_reg <= '0;
    end else if (tick_1s) begin
      sec_cnt_reg <= '0;
    end else if (tick_10ms) begin
      sec_cnt_reg <= sec_cnt_reg + 7'h01;
    end
  end
  assign tick_1s = tick_10ms &&
                   (sec_cnt_reg == SEC_CNT_W'(TICKS_PER_SEC - 1));

  // pulsed test signal for cross-circuit monitored inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_pulse_reg <= 1'b0;
    end else if (tick_10ms) begin
      test_pulse_reg <= !test_pulse_reg;
    end
  end
  assign test_pulse = test_pulse_reg;

  ////////////////////////////////////////////////////////////////////////
  // per-circuit evaluation: debounce and discrepancy monitoring
  for (genvar i = 0; i < NUM_CIRCUITS; i++) begin : g_circ
    logic                    a_on;
    logic                    b_on;
    logic [STABLE_CNT_W-1:0] stab_reg;
    logic [DISC_CNT_W-1:0]   disc_reg;
    logic                    warn_reg;

    // standard: steady high; monitored: echo of the test pulse
    assign a_on = cross_monitored[i] ? (channel_a[i] == test_pulse_reg)
                                     : channel_a[i];
    assign b_on = cross_monitored[i] ? (channel_b[i] == test_pulse_reg)
                                     : channel_b[i];

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        stab_reg <= '0;
      end else if (!(a_on && b_on)) begin
        stab_reg <= '0;
      end else if (tick_10ms && stab_reg != STABLE_CNT_W'(STABLE_TICKS)) begin
        stab_reg <= stab_reg + 4'h1;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        disc_reg <= '0;
      end else if (a_on == b_on) begin
        disc_reg <= '0;
      end else if (tick_10ms && disc_reg != DISC_CNT_W'(DISC_TICKS)) begin
        disc_reg <= disc_reg + 10'h001;
      end
    end

    // warning holds until both channels have opened
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        warn_reg <= 1'b0;
      end else if (disc_reg == DISC_CNT_W'(DISC_TICKS)) begin
        warn_reg <= 1'b1;
      end else if (!a_on && !b_on) begin
        warn_reg <= 1'b0;
      end
    end

    assign disc_warn[i] = warn_reg;
    assign closed[i]    = (stab_reg == STABLE_CNT_W'(STABLE_TICKS)) &&
                          !warn_reg;
  end

  assign discrepancy_warning = |(disc_warn & circuit_en);

  ////////////////////////////////////////////////////////////////////////
  // stored configuration, replaced only by a save
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lim0_reg  <= {NUM_LIMITS{ADC_MAX}};
      lim1_reg  <= {NUM_LIMITS{ADC_MAX}};
      delay_reg <= {NUM_TIMERS{DELAY_DEFAULT}};
    end else if (cfg_save) begin
      lim0_reg <= cfg_limit_zero;
      lim1_reg <= cfg_limit_one;
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (t < LONG_TIMER0) begin
          delay_reg[t] <= (cfg_timer_delay[t] > SHORT_MAX) ? SHORT_MAX
                          : cfg_timer_delay[t];
        end else begin
          delay_reg[t] <= (cfg_timer_delay[t] > LONG_MAX) ? LONG_MAX
                          : cfg_timer_delay[t];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analogue limits: first releases interlock, fourth stops
  assign analog_trip = (analogue_channel_zero > lim0_reg[LIM_ESTOP]) ||
                       (analogue_channel_one  > lim1_reg[LIM_ESTOP]);
  assign analog_release =
    (analogue_channel_zero < lim0_reg[LIM_RELEASE]) &&
    (analogue_channel_one  < lim1_reg[LIM_RELEASE]) &&
    (analogue_channel_zero < lim0_reg[1]) &&
    (analogue_channel_one  < lim1_reg[1]) &&
    (analogue_channel_zero < lim0_reg[2]) &&
    (analogue_channel_one  < lim1_reg[2]) && !analog_trip;

  // broken wire in dual mode: channels spread beyond tolerance
  assign ai_diff = (analogue_channel_zero > analogue_channel_one)
                 ? analogue_channel_zero - analogue_channel_one
                 : analogue_channel_one - analogue_channel_zero;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wire_break_reg <= 1'b0;
    end else begin
      wire_break_reg <= dual_sensor && (ai_diff > dual_tolerance);
    end
  end
  assign wire_break_warning = wire_break_reg;

  ////////////////////////////////////////////////////////////////////////
  // start/reset, power-on arming and the enable latch
  assign circuit_ok  = &(closed | ~circuit_en);
  assign estop_used  = |(circuit_en & estop_circuit);
  assign auto_all    = &(auto_start | ~circuit_en);
  assign start_pulse = restart_input && !start_prev_reg;
  assign start_take  = start_pulse && !any_stop1;
  assign forced      = power_fail || system_fault || error_reg;
  assign run_cond    = circuit_ok && !analog_trip && !forced;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_prev_reg <= 1'b0;
      start_seen_reg <= 1'b0;
    end else begin
      start_prev_reg <= restart_input;
      if (start_take) begin
        start_seen_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= run_cond && (!estop_used || start_seen_reg || start_take) &&
                 (run_reg || auto_all || start_take);
    end
  end
  assign safety_enable = run_reg;

  // fault latch: set wins, selector restarts once cause is gone
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_reg <= 1'b0;
    end else if (power_fail || system_fault) begin
      error_reg <= 1'b1;
    end else if (error_view && selector_press) begin
      error_reg <= 1'b0;
    end
  end
  assign error_active = error_reg;

  ////////////////////////////////////////////////////////////////////////
  // timers: five shutdown paths, signalling on-delay, two long timers
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
    assign tif[t].tick      = (t < LONG_TIMER0) ? tick_10ms : tick_1s;
    assign tif[t].delay     = delay_reg[t];
    assign tif[t].force_off = (t < LONG_TIMER0) && forced;
    if (t < NUM_PATHS) begin : g_path
      assign tif[t].demand = run_reg;
      delay_timer #(.ON_DELAY(1'b0)) u_tmr (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tif     (tif[t])
      );
    end else begin : g_on
      if (t == SIGNAL_TIMER) begin : g_sig
        assign tif[t].demand = run_reg;
      end else begin : g_long
        assign tif[t].demand = long_timer_start[t - LONG_TIMER0];
      end
      delay_timer #(.ON_DELAY(1'b1)) u_tmr (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tif     (tif[t])
      );
    end
  end

  assign any_stop1 = tif[0].running || tif[1].running ||
                     tif[2].running || tif[3].running || tif[4].running;
  assign semiconductor_output_a = tif[1].out;
  assign semiconductor_output_b = tif[2].out;
  assign relay_output_a         = tif[3].out;
  assign relay_output_b         = tif[4].out;
  assign signalling_output_two  = tif[SIGNAL_TIMER].out;
  assign long_timer_done        = {tif[7].out, tif[6].out};

  ////////////////////////////////////////////////////////////////////////
  // interlock: lock state, unlock release and solenoid drive
  assign interlock_locked = interlock_electronic
                          ? (!lock_input_even && !lock_input_odd)
                          : !lock_input_odd;
  assign solenoid_on = power_to_unlock ? (unlock_request && permit_reg)
                                       : !(unlock_request && permit_reg);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      permit_reg <= 1'b0;
    end else begin
      permit_reg <= interlock_sel && analog_release;
    end
  end
  assign unlock_permit = permit_reg;

  // pair follows the solenoid when an interlock is selected
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_reg <= 1'b0;
    end else if (forced) begin
      comp_reg <= 1'b0;
    end else begin
      comp_reg <= interlock_sel ? solenoid_on : tif[0].out;
    end
  end
  assign complementary_safe_output   = comp_reg;
  assign complementary_safe_output_n = !comp_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_enable_cause;
    @(posedge ref_clk) disable iff (!rst_n)
    safety_enable |-> $past(circuit_ok) && !$past(analog_trip);
  endproperty
  a_enable_cause: assert property (p_enable_cause)
    else $error("enable without closed circuits");

  property p_estop_arm;
    @(posedge ref_clk) disable iff (!rst_n)
    (estop_used && !start_seen_reg && !start_take) |=> !safety_enable;
  endproperty
  a_estop_arm: assert property (p_estop_arm)
    else $error("enable before first start");

  property p_start_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
    (start_pulse && any_stop1 && !run_reg && !auto_all) |=> !run_reg;
  endproperty
  a_start_ignored: assert property (p_start_ignored)
    else $error("start taken during after-travel");

  property p_power_fail;
    @(posedge ref_clk) disable iff (!rst_n)
    power_fail |=> !semiconductor_output_a && !relay_output_b &&
                   !complementary_safe_output ##1 !safety_enable;
  endproperty
  a_power_fail: assert property (p_power_fail)
    else $error("path on after power fail");

  property p_auto_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (run_cond && auto_all && (!estop_used || start_seen_reg))
      |=> safety_enable;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("auto start did not enable");

  property p_analog_stop;
    @(posedge ref_clk) disable iff (!rst_n)
    analog_trip |=> !safety_enable;
  endproperty
  a_analog_stop: assert property (p_analog_stop)
    else $error("enable with analogue above stop limit");

  property p_zero_delay;
    @(posedge ref_clk) disable iff (!rst_n)
    ($fell(run_reg) && delay_reg[3] == DELAY_DEFAULT)
      |=> !relay_output_a;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay path stayed on");

  property p_unlock;
    @(posedge ref_clk) disable iff (!rst_n)
    unlock_permit |-> $past(interlock_sel) &&
      $past(analogue_channel_zero < lim0_reg[LIM_RELEASE]);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock permitted above release limit");

  property p_cfg_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !cfg_save |=> $stable(delay_reg) && $stable(lim0_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed without save");
endmodule

//--- testbench/sensor_field_model.sv
// sensor field model: contacts on the input circuits
`timescale 1ns/10ps
module sensor_field_model (
  input  wire logic       test_pulse,
  input  wire logic [7:0] closed,
  input  wire logic [7:0] cross_monitored,
  input  wire logic [7:0] split,
  output      logic [7:0] channel_a,
  output      logic [7:0] channel_b
);
  // monitored contact echoes the pulse when closed, its inverse when open
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      channel_a[i] = cross_monitored[i] ? closed[i] ~^ test_pulse : closed[i];
      channel_b[i] = channel_a[i] ^ split[i]; // split breaks channel b
    end
  end
endmodule

//--- testbench/tb.sv
// self-checking bench for the safety enable and shutdown logic
`timescale 1ns/10ps
module tb;
  import safety_pkg::*;
  logic ref_clk, rst_n, restart_input, dual_sensor, power_fail, system_fault;
  logic error_view, selector_press, cfg_save, interlock_sel, test_pulse;
  logic interlock_electronic, lock_input_even, lock_input_odd;
  logic [7:0] circuit_en, channel_a, channel_b, cross_monitored;
  logic [7:0] auto_start, estop_circuit, closed, split;
  logic [1:0] long_timer_done, long_timer_start;
  logic safety_enable, complementary_safe_output, complementary_safe_output_n;
  logic semiconductor_output_a, semiconductor_output_b, relay_output_a;
  logic relay_output_b, signalling_output_two, interlock_locked;
  logic unlock_permit, wire_break_warning, discrepancy_warning, error_active;
  adc_type         analogue_channel_zero, analogue_channel_one, dual_tolerance;
  adc_type   [3:0] cfg_limit_zero, cfg_limit_one;
  delay_type [7:0] cfg_timer_delay;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  wire logic [4:0] paths = {complementary_safe_output, semiconductor_output_a,
    semiconductor_output_b, relay_output_a, relay_output_b};

  safety_enable_shutdown_logic #(.TICK_CYCLES_P(10))
    safety_enable_shutdown_logic_inst (.ref_clk, .rst_n, .circuit_en,
    .channel_a, .channel_b, .cross_monitored, .auto_start, .estop_circuit,
    .test_pulse, .restart_input, .analogue_channel_zero, .analogue_channel_one,
    .dual_sensor, .dual_tolerance, .power_fail, .system_fault, .error_view,
    .selector_press, .cfg_save, .cfg_limit_zero, .cfg_limit_one,
    .cfg_timer_delay, .interlock_sel, .interlock_electronic,
    .power_to_unlock(1'b0), .lock_input_even, .lock_input_odd,
    .unlock_request(1'b0), .long_timer_start, .safety_enable,
    .complementary_safe_output, .complementary_safe_output_n,
    .semiconductor_output_a, .semiconductor_output_b, .relay_output_a,
    .relay_output_b, .signalling_output_two, .long_timer_done,
    .interlock_locked, .unlock_permit, .wire_break_warning,
    .discrepancy_warning, .error_active);
  sensor_field_model sensor_field_model_inst (.test_pulse, .closed,
    .cross_monitored, .split, .channel_a, .channel_b);

  ////////////////////////////////////////////////////////////////////////////
  // clock and cycle ceiling
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic press();
    @(posedge ref_clk) restart_input <= 1'b1;
    @(posedge ref_clk) restart_input <= 1'b0;
    cyc(2);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic start_with_estop();
    cyc(150);
    check(safety_enable, 1'b0);
    press();
    check(safety_enable, 1'b1);
    check(paths, 5'h1f);
    cyc(3);
    check(signalling_output_two, 1'b1);
  endtask
  task automatic analogue_trip_and_after_travel();
    @(posedge ref_clk) analogue_channel_zero <= 12'h801;
    cyc(3);
    check(safety_enable, 1'b0);
    check({complementary_safe_output, semiconductor_output_a}, 2'h1);
    @(posedge ref_clk) analogue_channel_zero <= 12'h000;
    press();
    check(safety_enable, 1'b0);
    cyc(230);
    check(semiconductor_output_a, 1'b0);
    press();
    check(safety_enable, 1'b1);
  endtask
  task automatic supply_drop();
    @(posedge ref_clk) power_fail <= 1'b1;
    cyc(2);
    check({paths, error_active}, 6'h01);
    @(posedge ref_clk) power_fail <= 1'b0;
    error_view <= 1'b1;
    selector_press <= 1'b1;
    @(posedge ref_clk) error_view <= 1'b0;
    selector_press <= 1'b0;
    cyc(2);
    check(error_active, 1'b0);
    press();
  endtask
  task automatic auto_restart();
    @(posedge ref_clk) auto_start <= 8'hff;
    closed <= 8'h02;
    cyc(5);
    @(posedge ref_clk) closed <= 8'h03;
    cyc(150);
    check(safety_enable, 1'b1);
  endtask
  task automatic interlock_and_wire();
    @(posedge ref_clk) interlock_sel <= 1'b1;
    lock_input_even <= 1'b1;
    cfg_limit_zero[3] <= 12'h000;
    cyc(3);
    check({unlock_permit, interlock_locked}, 2'h3);
    check(safety_enable, 1'b1);
    @(posedge ref_clk) analogue_channel_one <= 12'h200;
    lock_input_odd <= 1'b1;
    dual_sensor <= 1'b1;
    cyc(3);
    check({unlock_permit, interlock_locked}, 2'h0);
    check({wire_break_warning, safety_enable}, 2'h3);
  endtask
  task automatic discrepancy_and_long_timers();
    @(posedge ref_clk) split <= 8'h02;
    long_timer_start <= 2'h3;
    cyc(3);
    check({safety_enable, long_timer_done}, 3'h2);
    cyc(10020);
    check({discrepancy_warning, long_timer_done}, 3'h7);
    @(posedge ref_clk) split <= 8'h00;
    cyc(150);
    check(safety_enable, 1'b0);
    @(posedge ref_clk) closed <= 8'h01;
    cyc(3);
    check(discrepancy_warning, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {ref_clk, rst_n, restart_input, power_fail, system_fault} = '0;
    {error_view, selector_press, cfg_save, interlock_sel} = '0;
    {interlock_electronic, lock_input_even, lock_input_odd} = '0;
    {analogue_channel_zero, analogue_channel_one} = '0;
    {dual_sensor, dual_tolerance, auto_start} = '0;
    {circuit_en, closed, estop_circuit, cross_monitored} = 32'h0303_0201;
    {split, long_timer_start} = '0;
    cfg_limit_zero = {12'h800, 12'h700, 12'h700, 12'h100};
    cfg_limit_one = cfg_limit_zero;
    cfg_timer_delay = '0;
    cfg_timer_delay[1] = 16'h0014;
    cfg_timer_delay[6] = 16'h0001;
    repeat (3) @(posedge ref_clk);
    check({safety_enable, complementary_safe_output_n}, 2'h1);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk) cfg_save <= 1'b1;
    @(posedge ref_clk) cfg_save <= 1'b0;
    dual_tolerance <= 12'h010;
    start_with_estop();
    analogue_trip_and_after_travel();
    supply_drop();
    auto_restart();
    interlock_and_wire();
    discrepancy_and_long_timers();
    tally_and_finish();
  end
endmodule
